// ---- src/mcu_io_port_unit_consts.svh ----
// Named constants for the microcontroller I/O port unit
`ifndef MCU_IO_PORT_UNIT_CONSTS_SVH
`define MCU_IO_PORT_UNIT_CONSTS_SVH
// ------------------------------------------------------------
// Port addresses seen by I/O instructions
// ------------------------------------------------------------
`define PA_FIRST       5'h00
`define PA_LAST        5'h1f
`define PA_GEN_A       5'h04
`define PA_GEN_B       5'h05
`define PA_GEN_C       5'h06
`define PA_GEN_D       5'h07
`define PA_SHARED      5'h08
`define PA_SERIAL      5'h09
`define PA_SENSE       5'h0e
// ------------------------------------------------------------
// Instruction timing: states per cycle, sample and update states
// ------------------------------------------------------------
`define ST_S1          2'h0
`define ST_S3          2'h2
`define ST_S4          2'h3
// ------------------------------------------------------------
// Reset values and pin positions
// ------------------------------------------------------------
`define LATCH4_RST     4'hf
`define LATCH3_RST     3'h7
`define PULSE_BIT      1
`define HI_IRQ_BIT     2
`define LO_IRQ_BIT     0
`define CNT1_BIT       3
`define CNT2_BIT       1
`define IDX_MISSING    4'hf
// ------------------------------------------------------------
// Register bus map (byte addresses) and fields
// ------------------------------------------------------------
`define RA_CTRL        5'h00
`define RA_STATUS      5'h04
`define RA_MASK        5'h08
`define RA_PEND        5'h0c
`define RA_LATCH       5'h10
`define EV_HI          0
`define EV_LO          1
`define EV_TAKE        2
`define EV_DONE        3
`define EV_W           4
`endif

// ---- src/mcu_io_port_unit_pkg.sv ----
// Types shared by the I/O port unit
package mcu_io_port_unit_pkg;
  // I/O instruction kinds
  typedef enum logic [2:0] {
    KIND_IN, KIND_OUT, KIND_SET, KIND_CLR, KIND_TEST
  } io_kind_type;
  // Two-cycle instruction sequencer
  typedef enum logic [1:0] {
    SEQ_IDLE, SEQ_CYCLE1, SEQ_CYCLE2
  } seq_state_type;
endpackage : mcu_io_port_unit_pkg

// ---- src/mcu_io_port_unit.sv ----
// Port unit: latched I/O ports, instruction timing, external interrupt latches
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`include "mcu_io_port_unit_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mcu_io_port_unit
  import mcu_io_port_unit_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // Avalon-MM slave
  input  wire logic [4:0] AVS_ADDRESS_I,
  input  wire logic       AVS_READ_I,
  input  wire logic       AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]     AVS_READDATA_O,
  output logic            AVS_WAITREQUEST_O,
  output logic            IRQ_O,
  // Instruction sequencer side
  input  wire logic       IO_START_I,
  input  wire logic [2:0] IO_KIND_I,
  input  wire logic [4:0] IO_ADDR_I,
  input  wire logic [3:0] IO_WDATA_I,
  input  wire logic [3:0] IO_INDEX_I,
  input  wire logic       RETURN_FROM_IRQ_I,
  output logic            IO_BUSY_O,
  output logic            IO_DONE_O,
  output logic [3:0]      IO_RDATA_O,
  output logic            IO_TEST_O,
  output logic            IRQ_TAKE_HI_O,
  output logic            IRQ_TAKE_LO_O,
  // Peripheral command/status/data ports
  output logic            PERIPH_STB_O,
  output logic            PERIPH_WR_O,
  output logic [4:0]      PERIPH_ADDR_O,
  output logic [3:0]      PERIPH_WDATA_O,
  input  wire logic [3:0] PERIPH_RDATA_I,
  // Peripheral functions sharing pins
  input  wire logic       PULSE_I,
  input  wire logic [2:0] SIO_OE_I,
  input  wire logic [2:0] SIO_DO_I,
  output logic [7:0]      ADC_AIN_O,
  output logic            COUNTER1_O,
  output logic            COUNTER2_O,
  output logic [2:0]      SIO_DI_O,
  // Pins (open drain: output low when enabled)
  input  wire logic [3:0] GEN_A_I,
  input  wire logic [3:0] GEN_B_I,
  input  wire logic [3:0] GEN_C_I,
  input  wire logic [2:0] GEN_D_I,
  input  wire logic [3:0] SHARED_I,
  input  wire logic [2:0] SERIAL_I,
  input  wire logic       SENSE_I,
  output logic [3:0]      GEN_A_O,
  output logic [3:0]      GEN_B_O,
  output logic [3:0]      GEN_C_O,
  output logic [2:0]      GEN_D_O,
  output logic [3:0]      SHARED_O,
  output logic [2:0]      SERIAL_O,
  output logic [3:0]      GEN_A_OE_O,
  output logic [3:0]      GEN_B_OE_O,
  output logic [3:0]      GEN_C_OE_O,
  output logic [2:0]      GEN_D_OE_O,
  output logic [3:0]      SHARED_OE_O,
  output logic [2:0]      SERIAL_OE_O
);

  // Port address width is fixed by the 32-entry map
  if (ADDR_W != 5) begin : g_bad_addr
    $error("ADDR_W must be 5");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  seq_state_type seq_state;       // Sequencer state
  logic [1:0]    sub_state;       // S1..S4 within a cycle
  io_kind_type   cur_kind;        // Held instruction kind
  logic [4:0]    cur_addr;        // Held port address
  logic [3:0]    cur_wdata;       // Held output data
  logic [3:0]    cur_index;       // Held index register
  logic [3:0]    snap;            // Value sampled at S3
  logic [3:0]    latch_a;         // Output latches
  logic [3:0]    latch_b;
  logic [3:0]    latch_c;
  logic [2:0]    latch_d;
  logic [3:0]    latch_sh;
  logic [2:0]    latch_ser;
  logic [3:0]    shared_prev;     // Last shared-port pin levels
  logic          hi_pend;         // High-priority request latch
  logic          lo_pend;         // Low-priority request latch
  logic          master_en;       // Interrupt master enable
  logic [3:0]    irq_en;          // Interrupt enable register
  logic [`EV_W-1:0] ev_status;    // Sticky events
  logic [`EV_W-1:0] ev_mask;      // Event mask
  logic          bus_hit;         // Request sampled with waitrequest low

  wire take_start  = IO_START_I && (seq_state == SEQ_IDLE);
  wire sample_now  = (seq_state == SEQ_CYCLE2) && (sub_state == `ST_S3);
  wire update_now  = (seq_state == SEQ_CYCLE2) && (sub_state == `ST_S4);
  wire is_bitop    = (cur_kind == KIND_SET) || (cur_kind == KIND_CLR) ||
                     (cur_kind == KIND_TEST);
  wire hi_fall     = shared_prev[`HI_IRQ_BIT] && !SHARED_I[`HI_IRQ_BIT];
  wire lo_fall     = shared_prev[`LO_IRQ_BIT] && !SHARED_I[`LO_IRQ_BIT];
  wire acc_hi      = master_en && hi_pend && (seq_state == SEQ_IDLE);
  wire acc_lo      = master_en && lo_pend && irq_en[0] && !hi_pend &&
                     (seq_state == SEQ_IDLE);
  wire [14:0] gen_flat = {latch_d, latch_c, latch_b, latch_a};
  wire bus_wr      = bus_hit && AVS_WRITE_I;
  wire bus_rd      = bus_hit && AVS_READ_I;

  // ------------------------------------------------------------
  // Sequencer: two cycles of four states
  // ------------------------------------------------------------
  // Advances one state per clock; a new start is ignored while busy
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      seq_state <= SEQ_IDLE;
      sub_state <= `ST_S1;
    end else begin
      unique case (seq_state)
        SEQ_IDLE: begin
          sub_state <= `ST_S1;
          if (take_start) begin
            seq_state <= SEQ_CYCLE1;
          end
        end
        SEQ_CYCLE1: begin
          sub_state <= sub_state + 2'h1;
          if (sub_state == `ST_S4) begin
            seq_state <= SEQ_CYCLE2;
          end
        end
        SEQ_CYCLE2: begin
          sub_state <= sub_state + 2'h1;
          if (sub_state == `ST_S4) begin
            seq_state <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Capture the instruction operands at start
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cur_kind  <= KIND_IN;
      cur_addr  <= `PA_FIRST;
      cur_wdata <= 4'h0;
      cur_index <= 4'h0;
    end else if (take_start) begin
      cur_kind  <= io_kind_type'(IO_KIND_I);
      cur_addr  <= IO_ADDR_I;
      cur_wdata <= IO_WDATA_I;
      cur_index <= IO_INDEX_I;
    end
  end

  // ------------------------------------------------------------
  // Input sampling at S3
  // ------------------------------------------------------------
  // Pins pass straight through here: no input latch, so chatter shows
  logic [3:0] next_snap;
  always_comb begin
    next_snap = 4'h0;
    if (is_bitop) begin
      // Upper index bits choose the port, lower the pin
      unique case (cur_index[3:2])
        2'h0: next_snap = GEN_A_I;
        2'h1: next_snap = GEN_B_I;
        2'h2: next_snap = GEN_C_I;
        2'h3: next_snap = {1'b1, GEN_D_I};
      endcase
    end else begin
      unique case (cur_addr)
        `PA_GEN_A:  next_snap = GEN_A_I;
        `PA_GEN_B:  next_snap = GEN_B_I;
        `PA_GEN_C:  next_snap = GEN_C_I;
        `PA_GEN_D:  next_snap = {1'b1, GEN_D_I};
        `PA_SHARED: next_snap = SHARED_I;
        `PA_SERIAL: next_snap = {1'b0, SERIAL_I};
        `PA_SENSE:  next_snap = {2'h0, 1'b0, !SENSE_I};
        default:    next_snap = PERIPH_RDATA_I;
      endcase
    end
  end

  // Sample only at S3 of the second cycle
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      snap <= 4'h0;
    end else if (sample_now) begin
      snap <= next_snap;
    end
  end

  // ------------------------------------------------------------
  // Output latches, written at S4
  // ------------------------------------------------------------
  // Read-modify-write on the latch, not the pin, so other bits hold
  logic [3:0] bit_mask;
  always_comb begin
    bit_mask = 4'h0;
    bit_mask[cur_index[1:0]] = 1'b1;
  end

  function automatic logic [3:0] bit_apply(input logic [3:0] old,
                                           input logic [3:0] mask,
                                           input logic       set);
    bit_apply = set ? (old | mask) : (old & ~mask);
  endfunction : bit_apply

  wire bit_wr  = update_now && ((cur_kind == KIND_SET) || (cur_kind == KIND_CLR));
  wire bit_set = (cur_kind == KIND_SET);
  wire out_wr  = update_now && (cur_kind == KIND_OUT);
  // Port D has no bit 3 latch; pad it with one so the shared helper fits
  wire [3:0] d_apply = bit_apply({1'b1, latch_d}, bit_mask, bit_set);

  // General port latches; reset to ones so pins start as inputs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      latch_a <= `LATCH4_RST;
      latch_b <= `LATCH4_RST;
      latch_c <= `LATCH4_RST;
      latch_d <= `LATCH3_RST;
    end else if (bit_wr && (cur_index != `IDX_MISSING)) begin
      unique case (cur_index[3:2])
        2'h0: latch_a <= bit_apply(latch_a, bit_mask, bit_set);
        2'h1: latch_b <= bit_apply(latch_b, bit_mask, bit_set);
        2'h2: latch_c <= bit_apply(latch_c, bit_mask, bit_set);
        2'h3: latch_d <= d_apply[2:0];
      endcase
    end else if (out_wr) begin
      if (cur_addr == `PA_GEN_A) latch_a <= cur_wdata;
      if (cur_addr == `PA_GEN_B) latch_b <= cur_wdata;
      if (cur_addr == `PA_GEN_C) latch_c <= cur_wdata;
      if (cur_addr == `PA_GEN_D) latch_d <= cur_wdata[2:0];
    end
  end

  // Shared and serial latches; the serial port has no bit 3 latch
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      latch_sh  <= `LATCH4_RST;
      latch_ser <= `LATCH3_RST;
    end else if (out_wr) begin
      if (cur_addr == `PA_SHARED) latch_sh <= cur_wdata;
      if (cur_addr == `PA_SERIAL) latch_ser <= cur_wdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Instruction results and peripheral strobe
  // ------------------------------------------------------------
  wire own_port = (cur_addr >= `PA_GEN_A && cur_addr <= `PA_SERIAL) ||
                  (cur_addr == `PA_SENSE);

  // Results appear together with the done pulse
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      IO_DONE_O      <= 1'b0;
      IO_BUSY_O      <= 1'b0;
      IO_RDATA_O     <= 4'h0;
      IO_TEST_O      <= 1'b0;
      PERIPH_STB_O   <= 1'b0;
      PERIPH_WR_O    <= 1'b0;
      PERIPH_ADDR_O  <= `PA_FIRST;
      PERIPH_WDATA_O <= 4'h0;
    end else begin
      IO_DONE_O    <= update_now;
      IO_BUSY_O    <= take_start || ((seq_state != SEQ_IDLE) && !update_now);
      // Other addresses are command, status or data ports elsewhere
      PERIPH_STB_O <= update_now && !is_bitop && !own_port;
      if (update_now) begin
        IO_RDATA_O     <= (cur_kind == KIND_IN) ? snap : 4'h0;
        IO_TEST_O      <= (cur_kind == KIND_TEST) && |(snap & bit_mask);
        PERIPH_WR_O    <= (cur_kind == KIND_OUT);
        PERIPH_ADDR_O  <= cur_addr;
        PERIPH_WDATA_O <= cur_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers and shared functions
  // ------------------------------------------------------------
  // Open drain: a zero latch pulls low; registered so outputs are flops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      GEN_A_O <= 4'h0; GEN_B_O <= 4'h0; GEN_C_O <= 4'h0;
      GEN_D_O <= 3'h0; SHARED_O <= 4'h0; SERIAL_O <= 3'h0;
      GEN_A_OE_O  <= 4'h0;
      GEN_B_OE_O  <= 4'h0;
      GEN_C_OE_O  <= 4'h0;
      GEN_D_OE_O  <= 3'h0;
      SHARED_OE_O <= 4'h0;
      SERIAL_OE_O <= 3'h0;
    end else begin
      GEN_A_OE_O  <= ~latch_a;
      GEN_B_OE_O  <= ~latch_b;
      GEN_C_OE_O  <= ~latch_c;
      GEN_D_OE_O  <= ~latch_d;
      // Pulse output only acts while its latch is zero
      GEN_D_OE_O[`PULSE_BIT] <= !latch_d[`PULSE_BIT] && !PULSE_I;
      SHARED_OE_O <= ~latch_sh;
      // Serial drive needs latch one; a zero latch just pulls low
      SERIAL_OE_O <= ~latch_ser | (latch_ser & SIO_OE_I & ~SIO_DO_I);
    end
  end

  // Input routing to peripherals; plain registers on synchronous pins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ADC_AIN_O   <= 8'h00;
      COUNTER1_O  <= 1'b1;
      COUNTER2_O  <= 1'b1;
      SIO_DI_O    <= 3'h7;
      shared_prev <= `LATCH4_RST;
    end else begin
      ADC_AIN_O   <= {GEN_B_I, GEN_A_I};
      COUNTER1_O  <= SHARED_I[`CNT1_BIT];
      COUNTER2_O  <= SHARED_I[`CNT2_BIT];
      SIO_DI_O    <= SERIAL_I;
      shared_prev <= SHARED_I;
    end
  end

  // ------------------------------------------------------------
  // External interrupt latches and acceptance
  // ------------------------------------------------------------
  // Edges latch even when the pin is plain I/O; set wins over clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hi_pend <= 1'b0;
      lo_pend <= 1'b0;
    end else begin
      if (hi_fall) hi_pend <= 1'b1;
      else if (acc_hi || (bus_wr && AVS_ADDRESS_I == `RA_PEND &&
                          AVS_WRITEDATA_I[0])) hi_pend <= 1'b0;
      if (lo_fall) lo_pend <= 1'b1;
      else if (acc_lo || (bus_wr && AVS_ADDRESS_I == `RA_PEND &&
                          AVS_WRITEDATA_I[1])) lo_pend <= 1'b0;
    end
  end

  // Master enable: cleared on acceptance, set by return or software
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      master_en     <= 1'b0;
      irq_en        <= 4'h0;
      IRQ_TAKE_HI_O <= 1'b0;
      IRQ_TAKE_LO_O <= 1'b0;
    end else begin
      IRQ_TAKE_HI_O <= acc_hi;
      IRQ_TAKE_LO_O <= acc_lo && !acc_hi;
      if (acc_hi || acc_lo) master_en <= 1'b0;
      else if (RETURN_FROM_IRQ_I) master_en <= 1'b1;
      else if (bus_wr && AVS_ADDRESS_I == `RA_CTRL) master_en <= AVS_WRITEDATA_I[0];
      if (bus_wr && AVS_ADDRESS_I == `RA_CTRL) irq_en <= AVS_WRITEDATA_I[7:4];
    end
  end

  // ------------------------------------------------------------
  // Register bus slave, one wait state
  // ------------------------------------------------------------
  logic [`EV_W-1:0] ev_set;
  assign ev_set = {update_now, acc_hi | acc_lo, lo_fall, hi_fall};

  // Waitrequest drops for one cycle per request
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      bus_hit           <= 1'b0;
      AVS_READDATA_O    <= 32'h0;
    end else begin
      bus_hit           <= (AVS_READ_I || AVS_WRITE_I) && !bus_hit;
      AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && !bus_hit);
      unique case (AVS_ADDRESS_I)
        `RA_CTRL:   AVS_READDATA_O <= {24'h0, irq_en, 3'h0, master_en};
        `RA_STATUS: AVS_READDATA_O <= {28'h0, ev_status};
        `RA_MASK:   AVS_READDATA_O <= {28'h0, ev_mask};
        `RA_PEND:   AVS_READDATA_O <= {30'h0, lo_pend, hi_pend};
        `RA_LATCH:  AVS_READDATA_O <= {10'h0, latch_ser, latch_sh, gen_flat};
        default:    AVS_READDATA_O <= 32'h0;
      endcase
    end
  end

  // Sticky status cleared by a read; a new event wins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ev_status <= '0;
      ev_mask   <= '0;
      IRQ_O     <= 1'b0;
    end else begin
      // Clear only what the read reported; an event after the snapshot stays
      if (bus_rd && AVS_ADDRESS_I == `RA_STATUS) begin
        ev_status <= (ev_status & ~AVS_READDATA_O[`EV_W-1:0]) | ev_set;
      end else begin
        ev_status <= ev_status | ev_set;
      end
      if (bus_wr && AVS_ADDRESS_I == `RA_MASK) ev_mask <= AVS_WRITEDATA_I[`EV_W-1:0];
      IRQ_O <= |(ev_status & ev_mask);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_out_at_s4: assert property (@(posedge CLK_I) disable iff (RST_I)
    take_start |-> ##9 IO_DONE_O) else $error("done not at S4 of cycle two");
  a_sample_s3: assert property (@(posedge CLK_I) disable iff (RST_I)
    take_start |-> ##7 sample_now ##1 update_now) else $error("sample not at S3");
  a_reset_ones: assert property (@(posedge CLK_I)
    $fell(RST_I) |-> (gen_flat == 15'h7fff)) else $error("latches not one after reset");
  a_bit_only: assert property (@(posedge CLK_I) disable iff (RST_I)
    bit_wr |=> ($countones(gen_flat ^ $past(gen_flat)) <= 1))
    else $error("other bits changed");
  a_latch_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !update_now |=> $stable(gen_flat)) else $error("latch changed outside S4");
  a_pulse_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
    GEN_D_OE_O[`PULSE_BIT] |-> !$past(latch_d[`PULSE_BIT])) else $error("pulse with latch one");
  a_d_bit3_one: assert property (@(posedge CLK_I) disable iff (RST_I)
    update_now && cur_kind == KIND_IN && cur_addr == `PA_GEN_D |=> IO_RDATA_O[3])
    else $error("missing bit not one");
  a_sense_inv: assert property (@(posedge CLK_I) disable iff (RST_I)
    update_now && cur_kind == KIND_IN && cur_addr == `PA_SENSE |=>
      (IO_RDATA_O[0] == !$past(SENSE_I, 2))) else $error("sense not inverted");
  a_lo_blocked: assert property (@(posedge CLK_I) disable iff (RST_I)
    IRQ_TAKE_LO_O |-> $past(irq_en[0]) && $past(master_en)) else $error("low taken while disabled");
  a_hi_edge: assert property (@(posedge CLK_I) disable iff (RST_I)
    hi_fall |=> hi_pend) else $error("high edge not latched");
  a_master_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
    (acc_hi || acc_lo) |=> !master_en ##0 $past(master_en)) else $error("master not cleared");

endmodule : mcu_io_port_unit
`default_nettype wire

// ---- tb/pin_world.sv ----
// Outside circuit on the open-drain pins: pull-ups plus forced lows
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input  wire logic [21:0] oe_i,  // Device pulling a pin low
  input  wire logic [21:0] low_i, // Outside circuit pulling low
  output logic      [21:0] pin_o  // Resolved pin level
);
  // A released pin floats up to one, never to its last value
  // Shared pins stay high for their functions unless pulled low
  assign pin_o = ~(oe_i | low_i);
endmodule : pin_world
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the port unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mcu_io_port_unit_pkg::*;
  logic        CLK_I = 0, RST_I = 1, AVS_READ_I = 0, AVS_WRITE_I = 0;
  logic        IO_START_I = 0, RETURN_FROM_IRQ_I = 0, PULSE_I = 0, SENSE_I = 0;
  logic [4:0]  AVS_ADDRESS_I = 0, IO_ADDR_I = 0;
  logic [31:0] AVS_WRITEDATA_I = 0, AVS_READDATA_O;
  logic [2:0]  IO_KIND_I = 0;
  logic [3:0]  IO_WDATA_I = 0, IO_INDEX_I = 0, PERIPH_RDATA_I = 0, IO_RDATA_O;
  logic        AVS_WAITREQUEST_O, IRQ_O, IO_DONE_O, IRQ_TAKE_HI_O, IRQ_TAKE_LO_O;
  logic        IO_BUSY_O, IO_TEST_O, PERIPH_STB_O, PERIPH_WR_O, COUNTER1_O, COUNTER2_O;
  logic [4:0]  PERIPH_ADDR_O;
  logic [3:0]  PERIPH_WDATA_O;
  logic [2:0]  SIO_OE_I = 0, SIO_DO_I = 0;
  logic [7:0]  ADC_AIN_O;
  logic [21:0] ext = 0; // Outside lows: A,B,C,D,shared,serial from bit 0
  wire  [21:0] pin, oe;
  int          n_fail = 0, cmp_count = 0, cyc = 0, n_hi = 0, n_lo = 0, n_stb = 0;

  mcu_io_port_unit uut (
    .CLK_I, .RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
    .AVS_READDATA_O, .AVS_WAITREQUEST_O, .IRQ_O, .IO_START_I, .IO_KIND_I, .IO_ADDR_I,
    .IO_WDATA_I, .IO_INDEX_I, .RETURN_FROM_IRQ_I, .IO_BUSY_O, .IO_DONE_O, .IO_RDATA_O,
    .IO_TEST_O, .IRQ_TAKE_HI_O, .IRQ_TAKE_LO_O, .PERIPH_STB_O, .PERIPH_WR_O,
    .PERIPH_ADDR_O, .PERIPH_WDATA_O, .PERIPH_RDATA_I, .PULSE_I, .SIO_OE_I,
    .SIO_DO_I, .ADC_AIN_O, .COUNTER1_O, .COUNTER2_O, .SIO_DI_O(),
    .GEN_A_I(pin[3:0]), .GEN_B_I(pin[7:4]), .GEN_C_I(pin[11:8]), .GEN_D_I(pin[14:12]),
    .SHARED_I(pin[18:15]), .SERIAL_I(pin[21:19]), .SENSE_I, .GEN_A_O(), .GEN_B_O(),
    .GEN_C_O(), .GEN_D_O(), .SHARED_O(), .SERIAL_O(), .GEN_A_OE_O(oe[3:0]),
    .GEN_B_OE_O(oe[7:4]), .GEN_C_OE_O(oe[11:8]), .GEN_D_OE_O(oe[14:12]),
    .SHARED_OE_O(oe[18:15]), .SERIAL_OE_O(oe[21:19]));
  pin_world world (.oe_i(oe), .low_i(ext), .pin_o(pin));

  always #50 CLK_I = ~CLK_I;
  // Count accept pulses and cut a hang short
  always @(posedge CLK_I) begin
    n_hi += (IRQ_TAKE_HI_O === 1'b1);
    n_lo += (IRQ_TAKE_LO_O === 1'b1);
    n_stb += (PERIPH_STB_O === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results;
    end
  end

  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Bus cycle: hold until waitrequest is seen low, then release
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge CLK_I);
    AVS_WRITE_I <= w; AVS_READ_I <= !w; AVS_ADDRESS_I <= a; AVS_WRITEDATA_I <= d;
    do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    r = AVS_READDATA_O;
    AVS_WRITE_I <= 0; AVS_READ_I <= 0;
  endtask : bus
  task rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(0, a, 0, r);
    chk("reg", r, e);
  endtask : rd
  // Two-cycle instruction; returns one cycle after done so OE has settled
  task io(input logic [2:0] k, input logic [4:0] a, input logic [3:0] d, ix);
    @(posedge CLK_I);
    IO_START_I <= 1; IO_KIND_I <= k; IO_ADDR_I <= a; IO_WDATA_I <= d; IO_INDEX_I <= ix;
    @(posedge CLK_I);
    IO_START_I <= 0;
    @(negedge CLK_I);
    chk("busy", IO_BUSY_O, 1);
    repeat (8) @(negedge CLK_I);
    chk("done", {IO_DONE_O, IO_BUSY_O}, 2'h2);
    @(negedge CLK_I);
  endtask : io

  task t_in;
    @(posedge CLK_I);
    ext <= 22'h0500c6; // Shared bits 3 and 1 pulled low for the counters
    PERIPH_RDATA_I <= 4'ha;
    io(0, 5'h04, 0, 0);
    chk("in_a", IO_RDATA_O, 4'h9);
    chk("ain", ADC_AIN_O, 8'h39);
    chk("cnt", {COUNTER1_O, COUNTER2_O}, 2'h0);
    io(0, 5'h0c, 0, 0);
    chk("in_periph", IO_RDATA_O, 4'ha);
    chk("periph_rd", {PERIPH_WR_O, PERIPH_ADDR_O}, 6'h0c);
    io(1, 5'h1c, 4'h6, 0);
    chk("periph_wr", {PERIPH_WR_O, PERIPH_ADDR_O, PERIPH_WDATA_O}, 10'h3c6);
    chk("periph_stb", n_stb, 2);
    @(posedge CLK_I);
    ext <= 0;
  endtask : t_in
  task t_out;
    io(1, 5'h04, 4'h5, 0);
    chk("out_a", oe[3:0], 4'ha);
    io(3, 0, 0, 4'h0);
    chk("clr_a0", oe[3:0], 4'hb);
    io(2, 0, 0, 4'h3);
    chk("set_a3", oe[3:0], 4'h3);
    io(4, 0, 0, 4'h3);
    chk("test_a3", IO_TEST_O, 1);
    io(4, 0, 0, 4'h0);
    chk("test_a0", IO_TEST_O, 0);
    io(0, 5'h04, 0, 0);
    chk("rd_a", IO_RDATA_O, 4'hc);
    io(1, 5'h04, 4'hf, 0);
    io(3, 0, 0, 4'h5);
    chk("clr_b1", oe[7:0], 8'h20);
  endtask : t_out
  task t_d;
    @(posedge CLK_I);
    ext[12] <= 1;
    io(0, 5'h07, 0, 0);
    chk("d_in", IO_RDATA_O, 4'he);
    chk("d_pulse_off", oe[14:12], 0);
    @(posedge CLK_I);
    ext[12] <= 0;
    io(3, 0, 0, 4'hd);
    chk("d_pulse_lo", oe[14:12], 3'h2);
    @(posedge CLK_I);
    PULSE_I <= 1;
    repeat (2) @(negedge CLK_I);
    chk("d_pulse_hi", oe[14:12], 0);
    io(2, 0, 0, 4'hd);
  endtask : t_d
  task t_sense;
    @(posedge CLK_I);
    SENSE_I <= 1;
    io(0, 5'h0e, 0, 0);
    chk("sense_hi", IO_RDATA_O[0], 0);
    @(posedge CLK_I);
    SENSE_I <= 0;
    SIO_OE_I <= 3'h1; // Serial drives a low on bit 0 only
    io(0, 5'h0e, 0, 0);
    chk("sense_lo", IO_RDATA_O[0], 1);
    chk("ser_drive", oe[21:19], 3'h1);
    io(1, 5'h09, 4'h0, 0);
    chk("ser_latch0", oe[21:19], 3'h7);
    io(1, 5'h09, 4'hf, 0);
  endtask : t_sense
  task t_irq;
    logic [31:0] r;
    bus(1, 5'h08, 32'h1, r);
    bus(0, 5'h04, 0, r);
    ext[17] <= 1;
    repeat (6) @(negedge CLK_I);
    chk("hi_blocked", n_hi, 0);
    chk("irq_up", IRQ_O, 1);
    rd(5'h04, 32'h1);
    repeat (2) @(negedge CLK_I);
    chk("irq_down", IRQ_O, 0);
    bus(1, 5'h00, 32'h1, r);
    repeat (6) @(negedge CLK_I);
    chk("hi_taken", n_hi, 1);
    rd(5'h00, 32'h0);
    ext[15] <= 1;
    bus(1, 5'h00, 32'h1, r);
    repeat (6) @(negedge CLK_I);
    chk("lo_blocked", n_lo, 0);
    rd(5'h00, 32'h1);
    bus(1, 5'h00, 32'h11, r);
    repeat (6) @(negedge CLK_I);
    chk("lo_taken", n_lo, 1);
    rd(5'h00, 32'h10);
    RETURN_FROM_IRQ_I <= 1;
    @(posedge CLK_I);
    RETURN_FROM_IRQ_I <= 0;
    rd(5'h00, 32'h11);
    rd(5'h14, 32'h0);
    ext <= 0;
  endtask : t_irq

  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    repeat (10) @(posedge CLK_I);
    RST_I <= 0;
    @(negedge CLK_I);
    chk("oe_rst", oe, 0);
    t_in;
    t_out;
    t_d;
    t_sense;
    t_irq;
    results;
  end
endmodule : tb
`default_nettype wire
